// file: hdl/crl_pkg.sv
/*
 * Shared constants for the comparator latch and reference control block:
 * register byte offsets, field positions, reset values and ratio figures.
 * Assumes a 32-bit Avalon-MM master and a 100 MHz system clock.
 */
// How it works
// R1: Ladder powered only while its enable bit set
// R2: Range bit plus four-bit code picks tap
// R3: Low range gives code over 24 times ladder
// R4: High range gives quarter plus code over 32
// R5: Source bit picks supply or external pins
// R6: Enable cleared clamps reference to ground, no current
// R7: Fixed-reference enable bit turns fixed reference on
// R8: Fast oscillator running keeps fixed reference on
// R9: Software waits settling time after fixed enable
// R10: Comparator 1 select routes ladder, else fixed
// R11: Comparator 2 select routes ladder, else fixed
// R12: Both selects clear stops ladder current
// R13: Software sets output enable, clears port direction
// R14: Latch set by cmp1/pulse, reset wins
// R15: Pulse bits self-clear; writing zero does nothing
// R16: Two config bits choose four pin routings
// R17: After reset pins carry raw comparator results
// R18: Enable bits gate comparator set and reset
// R19: Status bits show true comparator results
// R20: Bit7 puts inverted Q on pin2, bit6 Q on pin1
package crl_pkg;
    // =====================================================================
    // Register map (byte addresses)
    localparam logic [3:0] OFS_SR_LATCH_CONTROL   = 4'h0;
    localparam logic [3:0] OFS_LADDER_REF_CONTROL = 4'h4;
    localparam logic [3:0] OFS_CMP2_CONTROL_1     = 4'h8;
    localparam logic [3:0] OFS_STATUS             = 4'hc;

    // =====================================================================
    // Field positions
    localparam int BIT_LATCH_ROUTE_PIN2    = 7;
    localparam int BIT_LATCH_ROUTE_PIN1    = 6;
    localparam int BIT_CMP1_SET_ENABLE     = 5;
    localparam int BIT_CMP2_RESET_ENABLE   = 4;
    localparam int BIT_SOFT_SET_PULSE      = 3;
    localparam int BIT_SOFT_RESET_PULSE    = 2;
    localparam int BIT_FIXED_REF_ENABLE    = 0;
    localparam int BIT_LADDER_ENABLE       = 7;
    localparam int BIT_LADDER_OUT_ENABLE   = 6;
    localparam int BIT_LADDER_RANGE_SELECT = 5;
    localparam int BIT_LADDER_SOURCE_SEL   = 4;
    localparam int BIT_CMP1_RESULT         = 7;
    localparam int BIT_CMP2_RESULT         = 6;
    localparam int BIT_CMP1_REF_SELECT     = 5;
    localparam int BIT_CMP2_REF_SELECT     = 4;
    localparam int BIT_STAT_LATCH_Q        = 3;
    localparam int BIT_STAT_LADDER_CURRENT = 2;
    localparam int BIT_STAT_FIXED_ON       = 1;

    // =====================================================================
    // Reset values
    localparam logic [7:0] RST_SR_LATCH_CONTROL   = 8'h00;
    localparam logic [7:0] RST_LADDER_REF_CONTROL = 8'h00;
    localparam logic [1:0] RST_CMP_REF_SELECT     = 2'h0;

    // =====================================================================
    // Reference as a fraction of the ladder voltage, in 96ths
    localparam logic [6:0] RATIO_DENOM      = 7'h60;
    localparam logic [6:0] LOW_RANGE_STEP   = 7'h04; // 96/24
    localparam logic [6:0] HIGH_RANGE_BASE  = 7'h18; // 96/4
    localparam logic [6:0] HIGH_RANGE_STEP  = 7'h03; // 96/32
endpackage : crl_pkg

// file: hdl/crl_sr_latch.sv
/*
 * Reset-dominant set-reset latch core, registered on the system clock.
 * Assumes set and reset are already synchronised to clk.
 */
`timescale 1ns/10ps
module crl_sr_latch (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic set_in,
    input  wire logic reset_in,
    output logic      q
);
    import crl_pkg::*;

    typedef struct packed {
        logic q;
    } crl_latch_t;

    crl_latch_t st_reg;
    crl_latch_t st_next;

    // =====================================================================
    // Latch
    // Holding in a flop trades the true unclocked latch for glitch-free pins
    always_comb begin
        st_next = st_reg;
        if (reset_in) begin
            st_next.q = 1'b0; // [R14]
        end else if (set_in) begin
            st_next.q = 1'b1; // [R14]
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.q;

    property p_reset_dominant;
        @(posedge clk) disable iff (!rstn)
        reset_in |=> !q;
    endproperty
    a_reset_dominant: assert property (p_reset_dominant) // [R14]
        else $error("latch not cleared by reset input");

    property p_set_takes;
        @(posedge clk) disable iff (!rstn)
        (set_in && !reset_in) |=> q;
    endproperty
    a_set_takes: assert property (p_set_takes) // [R14]
        else $error("latch not set by set input");
endmodule : crl_sr_latch

// file: hdl/crl_top.sv
/*
 * Comparator latch and reference control: Avalon-MM register slave,
 * latch output routing, ladder reference code and reference steering.
 * Assumes comparator results and the oscillator flag arrive asynchronously
 * and the analog ladder acts on the control levels driven here.
 */
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module crl_top (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        cmp1_result,
    input  wire logic        cmp2_result,
    input  wire logic        fast_internal_oscillator,
    output logic             cmp1_pin,
    output logic             cmp2_pin,
    output logic             ladder_power,
    output logic             ladder_current,
    output logic             ladder_clamp,
    output logic             ladder_source_select,
    output logic             ladder_range_select,
    output logic [3:0]       ladder_level_code,
    output logic [6:0]       ladder_ratio_96,
    output logic             ladder_out_enable,
    output logic             fixed_ref_on,
    output logic             cmp1_ref_ladder,
    output logic             cmp2_ref_ladder
);
    import crl_pkg::*;

    typedef struct packed {
        logic       wait_n;
        logic [7:0] rdata;
        logic [7:0] lcr;
        logic [7:0] vrc;
        logic [1:0] rsel;
        logic [1:0] c1_sync;
        logic [1:0] c2_sync;
        logic [1:0] osc_sync;
        logic       pls_set;
        logic       pls_rst;
        logic       pin1;
        logic       pin2;
        logic       ladder_pwr;
        logic       ladder_cur;
        logic       clamp;
        logic [6:0] ratio;
        logic       fixed_on;
    } crl_state_t;

    crl_state_t st_reg;
    crl_state_t st_next;

    logic latch_q;
    logic latch_set;
    logic latch_reset;
    logic c1;
    logic c2;
    logic wr_acc;

    assign c1     = st_reg.c1_sync[1];
    assign c2     = st_reg.c2_sync[1];
    assign wr_acc = avs_write & st_reg.wait_n & avs_byteenable[0];

    // =====================================================================
    // Latch inputs
    assign latch_set   = (c1 & st_reg.lcr[BIT_CMP1_SET_ENABLE]) | st_reg.pls_set; // [R18]
    assign latch_reset = (c2 & st_reg.lcr[BIT_CMP2_RESET_ENABLE])
                       | st_reg.pls_rst; // [R18]

    crl_sr_latch u_latch (
        .clk      (clk),
        .rstn     (rstn),
        .set_in   (latch_set),
        .reset_in (latch_reset),
        .q        (latch_q)
    );

    // =====================================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.c1_sync  = {st_reg.c1_sync[0], cmp1_result};
        st_next.c2_sync  = {st_reg.c2_sync[0], cmp2_result};
        st_next.osc_sync = {st_reg.osc_sync[0], fast_internal_oscillator};
        st_next.pls_set  = 1'b0; // [R15]
        st_next.pls_rst  = 1'b0; // [R15]

        // One wait cycle per access; the answer lands on the second edge
        st_next.wait_n = 1'b0;
        if ((avs_read | avs_write) && !st_reg.wait_n) begin
            st_next.wait_n = 1'b1;
            st_next.rdata  = 8'h00;
            case (avs_address)
                OFS_SR_LATCH_CONTROL: begin
                    st_next.rdata = st_reg.lcr;
                end
                OFS_LADDER_REF_CONTROL: begin
                    st_next.rdata = st_reg.vrc;
                end
                OFS_CMP2_CONTROL_1: begin
                    st_next.rdata = {c1, c2, st_reg.rsel, 4'h0}; // [R19]
                end
                OFS_STATUS: begin
                    st_next.rdata = {c1, c2, 1'b0, 1'b0, latch_q, st_reg.ladder_cur,
                                     st_reg.fixed_on, 1'b0}; // [R19]
                end
                default: begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end

        if (wr_acc) begin
            case (avs_address)
                OFS_SR_LATCH_CONTROL: begin
                    // Pulse bits and bit 1 never stored: they read back zero
                    st_next.lcr = avs_writedata[7:0] & 8'hf1; // [R16]
                    st_next.pls_set = avs_writedata[BIT_SOFT_SET_PULSE]; // [R15]
                    st_next.pls_rst = avs_writedata[BIT_SOFT_RESET_PULSE]; // [R15]
                end
                OFS_LADDER_REF_CONTROL: begin
                    st_next.vrc = avs_writedata[7:0]; // [R2]
                end
                OFS_CMP2_CONTROL_1: begin
                    st_next.rsel = avs_writedata[BIT_CMP1_REF_SELECT:BIT_CMP2_REF_SELECT];
                end
                default: begin
                end
            endcase
        end

        // Pin routing from the latch configuration bits
        st_next.pin1 = st_reg.lcr[BIT_LATCH_ROUTE_PIN1] ? latch_q : c1; // [R20] [R16] [R17]
        st_next.pin2 = st_reg.lcr[BIT_LATCH_ROUTE_PIN2] ? ~latch_q : c2; // [R20] [R16] [R17]

        // Ladder controls
        st_next.ladder_pwr = st_reg.vrc[BIT_LADDER_ENABLE]; // [R1]
        st_next.ladder_cur = st_reg.vrc[BIT_LADDER_ENABLE] & (|st_reg.rsel); // [R10] [R11] [R12]
        st_next.clamp      = ~st_reg.vrc[BIT_LADDER_ENABLE]; // [R6]
        if (!st_reg.vrc[BIT_LADDER_ENABLE]) begin
            st_next.ratio = 7'h00; // [R6]
        end else if (st_reg.vrc[BIT_LADDER_RANGE_SELECT]) begin
            st_next.ratio = 7'(st_reg.vrc[3:0] * LOW_RANGE_STEP); // [R3]
        end else begin
            st_next.ratio = 7'(HIGH_RANGE_BASE + st_reg.vrc[3:0] * HIGH_RANGE_STEP); // [R4]
        end

        // Software owes a settling wait after this rises
        st_next.fixed_on = st_reg.lcr[BIT_FIXED_REF_ENABLE] | st_reg.osc_sync[1]; // [R7] [R8] [R9]
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg      <= '0;
            st_reg.lcr  <= RST_SR_LATCH_CONTROL; // [R17]
            st_reg.vrc  <= RST_LADDER_REF_CONTROL;
            st_reg.rsel <= RST_CMP_REF_SELECT;
        end else begin
            st_reg <= st_next;
        end
    end

    // =====================================================================
    // Outputs
    assign avs_readdata         = {24'h000000, st_reg.rdata};
    assign avs_waitrequest      = ~st_reg.wait_n;
    assign cmp1_pin             = st_reg.pin1;
    assign cmp2_pin             = st_reg.pin2;
    assign ladder_power         = st_reg.ladder_pwr;
    assign ladder_current       = st_reg.ladder_cur;
    assign ladder_clamp         = st_reg.clamp;
    assign ladder_source_select = st_reg.vrc[BIT_LADDER_SOURCE_SEL]; // [R5]
    assign ladder_range_select  = st_reg.vrc[BIT_LADDER_RANGE_SELECT]; // [R2]
    assign ladder_level_code    = st_reg.vrc[3:0]; // [R2]
    assign ladder_ratio_96      = st_reg.ratio;
    assign ladder_out_enable    = st_reg.vrc[BIT_LADDER_OUT_ENABLE];
    assign fixed_ref_on         = st_reg.fixed_on;
    assign cmp1_ref_ladder      = st_reg.rsel[1]; // [R10]
    assign cmp2_ref_ladder      = st_reg.rsel[0]; // [R11]

    // =====================================================================
    // Checks
    property p_pulse_once;
        @(posedge clk) disable iff (!rstn)
        (wr_acc && avs_address == OFS_SR_LATCH_CONTROL && avs_writedata[3])
            |=> st_reg.pls_set ##1 !st_reg.pls_set;
    endproperty
    a_pulse_once: assert property (p_pulse_once) // [R15]
        else $error("set pulse not a single cycle");

    property p_soft_set_latches;
        @(posedge clk) disable iff (!rstn)
        (st_reg.pls_set && !latch_reset) |=> latch_q;
    endproperty
    a_soft_set_latches: assert property (p_soft_set_latches) // [R14]
        else $error("software set did not set latch");

    property p_gate_set;
        @(posedge clk) disable iff (!rstn)
        (!st_reg.lcr[5] && !st_reg.pls_set && !latch_q) |=> !latch_q;
    endproperty
    a_gate_set: assert property (p_gate_set) // [R18]
        else $error("latch set while set path gated off");

    property p_no_current;
        @(posedge clk) disable iff (!rstn)
        (st_reg.rsel == 2'b00) |=> !ladder_current;
    endproperty
    a_no_current: assert property (p_no_current) // [R12]
        else $error("ladder current with both selects clear");

    property p_clamp;
        @(posedge clk) disable iff (!rstn)
        !st_reg.vrc[7] |=> (ladder_ratio_96 == 7'h00 && ladder_clamp && !ladder_power);
    endproperty
    a_clamp: assert property (p_clamp) // [R6]
        else $error("reference not clamped when disabled");

    property p_low_range;
        @(posedge clk) disable iff (!rstn)
        (st_reg.vrc[7] && st_reg.vrc[5])
            |=> ladder_ratio_96 == 7'($past(st_reg.vrc[3:0]) * 4);
    endproperty
    a_low_range: assert property (p_low_range) // [R3]
        else $error("low range ratio wrong");

    property p_high_range;
        @(posedge clk) disable iff (!rstn)
        (st_reg.vrc[7] && !st_reg.vrc[5])
            |=> ladder_ratio_96 == 7'(24 + $past(st_reg.vrc[3:0]) * 3);
    endproperty
    a_high_range: assert property (p_high_range) // [R4]
        else $error("high range ratio wrong");

    property p_osc_fixed;
        @(posedge clk) disable iff (!rstn)
        fast_internal_oscillator [*3] |=> fixed_ref_on;
    endproperty
    a_osc_fixed: assert property (p_osc_fixed) // [R8]
        else $error("fixed reference off while oscillator runs");

    property p_raw_route;
        @(posedge clk) disable iff (!rstn)
        (st_reg.lcr[7:6] == 2'b00) |=> (cmp1_pin == $past(c1) && cmp2_pin == $past(c2));
    endproperty
    a_raw_route: assert property (p_raw_route) // [R17]
        else $error("pins not carrying raw results");

    property p_inv_q;
        @(posedge clk) disable iff (!rstn)
        st_reg.lcr[7] |=> cmp2_pin == !$past(latch_q);
    endproperty
    a_inv_q: assert property (p_inv_q) // [R20]
        else $error("pin2 not inverted latch output");

    property p_pulse_rst_once;
        @(posedge clk) disable iff (!rstn)
        (wr_acc && avs_address == OFS_SR_LATCH_CONTROL && avs_writedata[BIT_SOFT_RESET_PULSE])
            |=> st_reg.pls_rst ##1 !st_reg.pls_rst;
    endproperty
    a_pulse_rst_once: assert property (p_pulse_rst_once) // [R15]
        else $error("reset pulse not a single cycle");

    property p_soft_reset_latches;
        @(posedge clk) disable iff (!rstn)
        st_reg.pls_rst |=> !latch_q;
    endproperty
    a_soft_reset_latches: assert property (p_soft_reset_latches) // [R14]
        else $error("software reset did not clear latch");

    property p_gate_reset;
        @(posedge clk) disable iff (!rstn)
        (!st_reg.lcr[BIT_CMP2_RESET_ENABLE] && !st_reg.pls_rst && latch_q) |=> latch_q;
    endproperty
    a_gate_reset: assert property (p_gate_reset) // [R18]
        else $error("latch cleared while reset path gated off");

    property p_fixed_enable;
        @(posedge clk) disable iff (!rstn)
        st_reg.lcr[BIT_FIXED_REF_ENABLE] |=> fixed_ref_on;
    endproperty
    a_fixed_enable: assert property (p_fixed_enable) // [R7]
        else $error("fixed reference off while enable bit set");

    property p_ladder_on;
        @(posedge clk) disable iff (!rstn)
        st_reg.vrc[BIT_LADDER_ENABLE] |=> (ladder_power && !ladder_clamp);
    endproperty
    a_ladder_on: assert property (p_ladder_on) // [R1]
        else $error("ladder not powered while enabled");

    property p_cmp1_current;
        @(posedge clk) disable iff (!rstn)
        (st_reg.vrc[BIT_LADDER_ENABLE] && st_reg.rsel[1]) |=> ladder_current;
    endproperty
    a_cmp1_current: assert property (p_cmp1_current) // [R10]
        else $error("no ladder current with cmp1 on ladder");

    property p_cmp2_current;
        @(posedge clk) disable iff (!rstn)
        (st_reg.vrc[BIT_LADDER_ENABLE] && st_reg.rsel[0]) |=> ladder_current;
    endproperty
    a_cmp2_current: assert property (p_cmp2_current) // [R11]
        else $error("no ladder current with cmp2 on ladder");

    property p_status_true;
        @(posedge clk) disable iff (!rstn)
        (avs_read && !st_reg.wait_n && avs_address == OFS_CMP2_CONTROL_1)
            |=> avs_readdata[7:6] == {$past(c1), $past(c2)};
    endproperty
    a_status_true: assert property (p_status_true) // [R19]
        else $error("result bits differ from comparators");
endmodule : crl_top

// file: testbench/crl_analog_model.sv
/*
 * Far-side model: two comparators fed by the ladder or fixed reference.
 * Assumes analog levels are given in 96ths of the ladder voltage.
 */
`timescale 1ns/10ps
module crl_analog_model #(
    parameter logic [6:0] FIXED_96 = 7'h0c
) (
    input  wire logic [6:0] vin1_96,
    input  wire logic [6:0] vin2_96,
    input  wire logic [6:0] ladder_ratio_96,
    input  wire logic       fixed_ref_on,
    input  wire logic       cmp1_ref_ladder,
    input  wire logic       cmp2_ref_ladder,
    output logic            cmp1_result,
    output logic            cmp2_result
);
    logic [6:0] fixed_96;
    // =====================================================================
    // Reference steering
    // A fixed reference that is off sits at ground, so any input above 0 trips
    assign fixed_96    = fixed_ref_on ? FIXED_96 : 7'h00;
    assign cmp1_result = vin1_96 > (cmp1_ref_ladder ? ladder_ratio_96 : fixed_96);
    assign cmp2_result = vin2_96 > (cmp2_ref_ladder ? ladder_ratio_96 : fixed_96);
endmodule : crl_analog_model

// file: testbench/tb_top.sv
/*
 * Self-checking bench for crl_top: Avalon-MM register tests with a model
 * of the comparators. Assumes the one-cycle waitrequest handshake.
 */
`timescale 1ns/10ps
module tb_top;
    import crl_pkg::*;
    logic        clk, rstn, avs_read, avs_write, osc, be0;
    logic [3:0]  avs_address, avs_byteenable, level;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        avs_waitrequest, cmp1_result, cmp2_result, cmp1_pin, cmp2_pin;
    logic        ladder_power, ladder_current, ladder_clamp, src_sel, rng_sel;
    logic        out_en, fixed_ref_on, ref1, ref2;
    logic [6:0]  ratio, vin1, vin2, exp_ratio;
    int          num_errors, checks_done, cycles;

    crl_top u_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cmp1_result(cmp1_result),
        .cmp2_result(cmp2_result), .fast_internal_oscillator(osc),
        .cmp1_pin(cmp1_pin), .cmp2_pin(cmp2_pin), .ladder_power(ladder_power),
        .ladder_current(ladder_current), .ladder_clamp(ladder_clamp),
        .ladder_source_select(src_sel), .ladder_range_select(rng_sel),
        .ladder_level_code(level), .ladder_ratio_96(ratio),
        .ladder_out_enable(out_en), .fixed_ref_on(fixed_ref_on),
        .cmp1_ref_ladder(ref1), .cmp2_ref_ladder(ref2));

    crl_analog_model u_model (.vin1_96(vin1), .vin2_96(vin2), .ladder_ratio_96(ratio),
        .fixed_ref_on(fixed_ref_on), .cmp1_ref_ladder(ref1), .cmp2_ref_ladder(ref2),
        .cmp1_result(cmp1_result), .cmp2_result(cmp2_result));

    // =====================================================================
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            test_done();
        end
    end

    // =====================================================================
    // Tasks
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Request held until an edge samples waitrequest low; data taken at that edge
    task automatic bus(input logic is_wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        avs_address    <= a;
        avs_writedata  <= {24'h0, d};
        avs_byteenable <= {3'h0, be0};
        avs_write      <= is_wr;
        avs_read       <= !is_wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic settle;
        repeat (6) @(negedge clk);
    endtask : settle

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        settle();
    endtask : wr

    task automatic rd_chk(input string name, input logic [3:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(name, rd, {24'h0, exp});
    endtask : rd_chk

    task automatic drive(input logic [6:0] v1, input logic [6:0] v2, input logic o);
        @(posedge clk);
        vin1 <= v1;
        vin2 <= v2;
        osc  <= o;
        settle();
    endtask : drive

    // =====================================================================
    // Main sequence
    initial begin
        rstn = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
        avs_writedata = 32'h0; avs_byteenable = 4'h0; be0 = 1'b1; osc = 1'b0;
        vin1 = 7'h00; vin2 = 7'h00; num_errors = 0; checks_done = 0; cycles = 0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        settle();
        // After reset both pins carry the raw comparator results, both low with inputs at zero
        check("pins", {cmp1_pin, cmp2_pin}, 2'b00);
        check("idle", {ladder_power, ladder_clamp, ladder_current, fixed_ref_on}, 4'h4);
        rd_chk("latch ctl", OFS_SR_LATCH_CONTROL, RST_SR_LATCH_CONTROL);
        rd_chk("ladder ctl", OFS_LADDER_REF_CONTROL, RST_LADDER_REF_CONTROL);
        rd_chk("cmp2 ctl", OFS_CMP2_CONTROL_1, 8'h00);
        rd_chk("unmapped", 4'h2, 8'h00);
        drive(7'h7f, 7'h00, 1'b0);
        check("raw pins", {cmp1_pin, cmp2_pin}, 2'b10);
        rd_chk("results", OFS_CMP2_CONTROL_1, 8'h80);
        be0 = 1'b0;
        wr(OFS_LADDER_REF_CONTROL, 8'hff);
        be0 = 1'b1;
        rd_chk("lane off", OFS_LADDER_REF_CONTROL, 8'h00);
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 16; c++) begin
                wr(OFS_LADDER_REF_CONTROL, {2'b11, r[0], r[0], c[3:0]});
                exp_ratio = (r != 0) ? 7'(c * 96 / 24) : 7'(96 / 4 + c * 96 / 32);
                check("ladder", {ladder_power, ladder_clamp, rng_sel, src_sel, out_en, level, ratio},
                    {2'b10, r[0], r[0], 1'b1, c[3:0], exp_ratio});
            end
        end
        for (int s = 0; s < 4; s++) begin
            wr(OFS_CMP2_CONTROL_1, {2'b00, s[1:0], 4'h0});
            check("ref steer", {ref1, ref2, ladder_current}, {s[1:0], s != 0});
        end
        drive(7'h3c, 7'h3d, 1'b0);
        rd_chk("ladder cmp", OFS_CMP2_CONTROL_1, 8'h70);
        wr(OFS_LADDER_REF_CONTROL, 8'h00);
        check("clamped", {ladder_power, ladder_clamp, ladder_current, ratio}, 10'h100);
        wr(OFS_CMP2_CONTROL_1, 8'h00);
        wr(OFS_SR_LATCH_CONTROL, 8'h01);
        check("fixed on", fixed_ref_on, 1'b1);
        // Reference needs time to settle before its results are trusted
        settle();
        wr(OFS_SR_LATCH_CONTROL, 8'h00);
        check("fixed off", fixed_ref_on, 1'b0);
        drive(7'h00, 7'h00, 1'b1);
        check("osc fixed", fixed_ref_on, 1'b1);
        drive(7'h00, 7'h00, 1'b0);
        wr(OFS_SR_LATCH_CONTROL, 8'hc8);
        check("soft set", {cmp1_pin, cmp2_pin}, 2'b10);
        rd_chk("pulse clr", OFS_SR_LATCH_CONTROL, 8'hc0);
        rd_chk("status q", OFS_STATUS, 8'h08);
        wr(OFS_SR_LATCH_CONTROL, 8'hcc);
        check("both soft", {cmp1_pin, cmp2_pin}, 2'b01);
        wr(OFS_SR_LATCH_CONTROL, 8'hc8);
        wr(OFS_SR_LATCH_CONTROL, 8'hc0);
        check("zero write", {cmp1_pin, cmp2_pin}, 2'b10);
        drive(7'h00, 7'h7f, 1'b0);
        check("c2 gated", {cmp1_pin, cmp2_pin}, 2'b10);
        for (int m = 0; m < 4; m++) begin
            wr(OFS_SR_LATCH_CONTROL, {m[1:0], 6'h00});
            check("route", {cmp1_pin, cmp2_pin}, {m[0], !m[1]});
        end
        rd_chk("true result", OFS_CMP2_CONTROL_1, 8'h40);
        wr(OFS_SR_LATCH_CONTROL, 8'hd0);
        check("c2 reset", {cmp1_pin, cmp2_pin}, 2'b01);
        drive(7'h7f, 7'h7f, 1'b0);
        wr(OFS_SR_LATCH_CONTROL, 8'hf0);
        check("cmp both", {cmp1_pin, cmp2_pin}, 2'b01);
        drive(7'h7f, 7'h00, 1'b0);
        check("c1 set", {cmp1_pin, cmp2_pin}, 2'b10);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        settle();
        check("rerouted", {cmp1_pin, cmp2_pin}, 2'b10);
        rd_chk("ctl again", OFS_SR_LATCH_CONTROL, 8'h00);
        test_done();
    end
endmodule : tb_top
